//--- ocp_load_model.sv
`timescale 1ns/1ns
// ------
// Load on the compare pin, with an overcurrent sense line
// ------
module ocp_load_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic clr,
  input wire logic trip,
  output logic fault_n,
  output int rises,
  output int width,
  output int per
);
  logic prev;
  int hc;
  int pc;
  // Sense line is driven both ways, so no pull level is needed
  assign fault_n = !trip;
  always_ff @(posedge clk_sys)
  begin
    prev <= pin;
    if (!rst_n || clr)
    begin
      rises <= 0;
      width <= 0;
      per <= 0;
      hc <= 0;
      pc <= 0;
    end
    else
    begin
      pc <= pc + 1;
      hc <= pin ? hc + 1 : 0;
      if (pin && !prev)
      begin
        rises <= rises + 1;
        per <= pc;
        pc <= 1;
      end
      if (!pin && prev)
        width <= hc;
    end
  end
endmodule

//--- ocp_map.svh
`ifndef OCP_MAP_SVH
`define OCP_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OCP_ADDR_CTRL 8'h00
`define OCP_ADDR_PRI 8'h04
`define OCP_ADDR_SEC 8'h08
`define OCP_ADDR_PER0 8'h0c
`define OCP_ADDR_PER1 8'h10
`define OCP_ADDR_TRUN 8'h14
`define OCP_ADDR_CNT0 8'h18
`define OCP_ADDR_CNT1 8'h1c
`define OCP_ADDR_IRQ 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OCP_CTRL_MODE_HI 2
`define OCP_CTRL_MODE_LO 0
`define OCP_CTRL_TSEL_BIT 3
`define OCP_CTRL_FLT_BIT 4
`define OCP_TRUN_RUN0_BIT 0
`define OCP_TRUN_RUN1_BIT 1
`define OCP_IRQ_FLAG_BIT 0
`define OCP_IRQ_EN_BIT 1
`define OCP_STRB_LO 0
`define OCP_STRB_HI 1

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_SET_HI 3'h1
`define OCP_MODE_SET_LO 3'h2
`define OCP_MODE_TOGGLE 3'h3
`define OCP_MODE_SINGLE 3'h4
`define OCP_MODE_CONT 3'h5
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWM_FLT 3'h7

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define OCP_RST_WORD 16'h0000
`define OCP_RST_MODE 3'h0
`define OCP_LAST_FAULT_A_CHANNEL 4

`endif

//--- ocp_pkg.sv
package ocp_pkg;
  typedef logic [7:0] ocp_addr_t;
  typedef logic [31:0] ocp_data_t;
  typedef logic [2:0] ocp_mode_t;
  typedef enum logic [1:0] {SP_ARMED, SP_HIGH, SP_DONE} ocp_pulse_state_t;
endpackage

//--- ocp_sync.sv
`timescale 1ns/1ns
module ocp_sync #(
  parameter int W = 2,
  parameter logic RST_LEVEL = 1'b1
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_reg <= {W{RST_LEVEL}};
      sync_out <= {W{RST_LEVEL}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

//--- ocp_testbench.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
  import ocp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  ocp_addr_t paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  ocp_data_t pwdata = 32'h0;
  ocp_data_t prdata;
  ocp_data_t rdv;
  logic pready, pslverr, serr, pin, irq, flt_n;
  logic clr = 1'b0;
  logic trip = 1'b0;
  logic flt_b_n = 1'b1;
  int rises, width, per;
  int err_count = 0;
  int compares = 0;
  always #5 clk_sys = ~clk_sys;
  ocp_top #(.CW(16), .CHANNEL_NUM(1)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_input_a_n(flt_n), .fault_input_b_n(flt_b_n),
    .compare_output_pin(pin), .compare_irq(irq));
  ocp_load_model i_load (.clk_sys(clk_sys), .rst_n(rst_n), .pin(pin), .clr(clr),
    .trip(trip), .fault_n(flt_n), .rises(rises), .width(width), .per(per));
  // ------
  // Bus and timing helpers
  // ------
  task automatic xfer(input logic w, input ocp_addr_t a, input ocp_data_t d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input ocp_addr_t a, input ocp_data_t d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input ocp_addr_t a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Model counters restart so each window is judged on its own
  task automatic clear_load();
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_simple();
    rd(8'h00);
    `CHK("ctrl reset", 32'h0, rdv)
    rd(8'h40);
    `CHK("unmapped err", 1'b1, serr)
    wr(8'h0c, 32'h9);
    wr(8'h04, 32'h4);
    wr(8'h14, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'((i + 1) % 4));
      cyc(0);
      `CHK("pin init", 4'b0010 >> i & 1, pin)
      cyc(10);
      `CHK("pin match", 4'b0101 >> i & 1, pin)
    end
    $display("done simple");
  endtask
  task automatic t_single();
    wr(8'h04, 32'h5);
    wr(8'h08, 32'ha);
    wr(8'h0c, 32'h14);
    wr(8'h00, 32'h4);
    cyc(0);
    `CHK("single init", 1'b0, pin)
    clear_load();
    cyc(42);
    `CHK("single rises", 1, rises)
    `CHK("single width", 5, width)
    rd(8'h20);
    `CHK("flag", 32'h1, rdv)
    `CHK("irq masked", 1'b0, irq)
    wr(8'h20, 32'h2);
    cyc(0);
    `CHK("irq on", 1'b1, irq)
    wr(8'h20, 32'h3);
    cyc(0);
    `CHK("irq cleared", 1'b0, irq)
    wr(8'h00, 32'h4);
    cyc(42);
    `CHK("rearm rises", 2, rises)
    `CHK("rearm irq", 1'b1, irq)
    $display("done single");
  endtask
  task automatic t_cont();
    wr(8'h10, 32'hf);
    wr(8'h00, 32'hd);
    cyc(0);
    `CHK("cont init", 1'b0, pin)
    wr(8'h14, 32'h3);
    wr(8'h20, 32'h3);
    cyc(20);
    clear_load();
    cyc(64);
    `CHK("cont rises", 4, rises)
    `CHK("cont period", 16, per)
    `CHK("cont width", 5, width)
    `CHK("cont irq", 1'b1, irq)
    $display("done cont");
  endtask
  task automatic t_pwm();
    wr(8'h14, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h0c, 32'h9);
    wr(8'h08, 32'h6);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h6);
    wr(8'h14, 32'h1);
    cyc(5);
    `CHK("first duty", 1'b0, pin)
    wr(8'h04, 32'h1);
    trip <= 1'b1;
    cyc(25);
    `CHK("pwm width", 6, width)
    `CHK("pwm period", 10, per)
    rd(8'h04);
    `CHK("duty ro", 32'h6, rdv)
    rd(8'h00);
    `CHK("no status", 32'h6, rdv)
    $display("done pwm");
  endtask
  task automatic t_fault();
    wr(8'h20, 32'h3);
    wr(8'h00, 32'h7);
    cyc(3);
    clear_load();
    cyc(20);
    `CHK("fault rises", 0, rises)
    `CHK("fault irq", 1'b1, irq)
    rd(8'h00);
    `CHK("status set", 32'h17, rdv)
    trip <= 1'b0;
    // Channel one must ignore the other fault line
    flt_b_n <= 1'b0;
    cyc(15);
    clear_load();
    cyc(20);
    `CHK("resume rises", 2, rises)
    rd(8'h00);
    `CHK("status clr", 32'h7, rdv)
    $display("done fault");
  endtask
  // ------
  // Run control
  // ------
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_simple();
    t_single();
    t_cont();
    t_pwm();
    t_fault();
    final_report();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    final_report();
  end
endmodule

//--- ocp_timebase.sv
`timescale 1ns/1ns
`include "ocp_map.svh"
module ocp_timebase #(
  parameter int CW = 16
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [CW-1:0] period,
  input wire logic cnt_wr,
  input wire logic [CW-1:0] cnt_wdata,
  output logic [CW-1:0] count,
  output logic period_match
);
  // ----------------------------------------
  // Free counter with period wrap
  // ----------------------------------------
  assign period_match = run && (count == period);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      count <= CW'(`OCP_RST_WORD);
    else if (cnt_wr)
      count <= cnt_wdata;
    else if (period_match)
      count <= CW'(`OCP_RST_WORD); // RULE7
    else if (run)
      count <= count + CW'(1);
  end
endmodule

//--- ocp_top.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "ocp_map.svh"
// Operation
// RULE1: Single-pulse code write drives pin low, arms
// RULE2: Pulse modes rise on first primary match
// RULE3: Single pulse falls at secondary match, stays
// RULE4: Ending secondary match sets interrupt flag
// RULE5: Rewriting single-pulse code re-arms the channel
// RULE6: Continuous mode: low start, rise/fall repeatedly
// RULE7: Timer count wraps to zero at period
// RULE8: Continuous mode flags every secondary match
// RULE9: Channel compares against one of two timers
// RULE10: Primary compare read-only during PWM
// RULE11: Secondary copied to duty at period match
// RULE12: Held primary value is first PWM duty
// RULE13: Timer period sets PWM period
// RULE14: Channels one-four fault A, five fault B
// RULE15: Software keeps period at least secondary value
// RULE16: Software loads primary before first enable
// RULE17: Software enables interrupt when using fault
// RULE18: Software pulse setup order is fixed
// RULE19: Software PWM setup order is fixed
// RULE20: Select one picks second timer, zero first
// RULE21: Code 111 PWM with fault, 110 without
// RULE22: Codes 011/010/001/000 single compare behaviours
// RULE23: Fault status read-only, hardware cleared
// RULE24: PWM high from period start until duty
// RULE25: Fault forces pin low, sets status, flag
module ocp_top #(
  parameter int CW = 16,
  parameter int CHANNEL_NUM = 1
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ocp_pkg::ocp_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ocp_pkg::ocp_data_t pwdata,
  input wire logic [3:0] pstrb,
  output ocp_pkg::ocp_data_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_input_a_n,
  input wire logic fault_input_b_n,
  output logic compare_output_pin,
  output logic compare_irq
);
  import ocp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ocp_mode_t mode_reg;
  logic tsel_reg;
  logic flt_status_reg;
  logic [CW-1:0] pri_reg;
  logic [CW-1:0] sec_reg;
  logic [CW-1:0] per0_reg;
  logic [CW-1:0] per1_reg;
  logic [1:0] run_reg;
  logic irq_flag_reg;
  logic irq_en_reg;
  logic pin_reg;
  ocp_pulse_state_t sp_state_reg;
  ocp_data_t rdata_reg;
  ocp_data_t rdata_next;
  logic [CW-1:0] cnt0;
  logic [CW-1:0] cnt1;
  logic pm0;
  logic pm1;
  logic [1:0] fault_sync_n;
  logic setup_phase;
  logic acc_wr;
  logic mapped;
  logic ctrl_wr;
  ocp_mode_t new_mode;
  logic [CW-1:0] sel_cnt;
  logic [CW-1:0] sel_per;
  logic sel_run;
  logic sel_pm;
  logic match_p;
  logic match_s;
  logic pwm_mode;
  logic pwm_level;
  logic fault_active;
  logic flag_set;
  logic flag_clr;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign setup_phase = psel && !penable;
  assign acc_wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_reg;

  always_comb
  begin
    unique case (paddr)
      `OCP_ADDR_CTRL, `OCP_ADDR_PRI, `OCP_ADDR_SEC, `OCP_ADDR_PER0, `OCP_ADDR_PER1,
      `OCP_ADDR_TRUN, `OCP_ADDR_CNT0, `OCP_ADDR_CNT1, `OCP_ADDR_IRQ: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped accesses are refused, writes to them have no effect
  assign pslverr = psel && penable && !mapped;

  assign ctrl_wr = acc_wr && (paddr == `OCP_ADDR_CTRL) && pstrb[`OCP_STRB_LO];
  assign new_mode = pwdata[`OCP_CTRL_MODE_HI:`OCP_CTRL_MODE_LO];

  // Byte-lane merge for the 16-bit registers
  function automatic logic [CW-1:0] merge16(
    input logic [CW-1:0] old_v,
    input ocp_data_t wd,
    input logic [3:0] strb
  );
    logic [CW-1:0] res;
    res = old_v;
    if (strb[`OCP_STRB_LO])
      res[7:0] = wd[7:0];
    if (strb[`OCP_STRB_HI])
      res[CW-1:8] = wd[CW-1:8];
    return res;
  endfunction

  // ----------------------------------------
  // Shared time bases
  // ----------------------------------------
  ocp_timebase #(
    .CW(CW)
  ) u_tb0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(run_reg[`OCP_TRUN_RUN0_BIT]),
    .period(per0_reg),
    .cnt_wr(acc_wr && (paddr == `OCP_ADDR_CNT0)),
    .cnt_wdata(merge16(cnt0, pwdata, pstrb)),
    .count(cnt0),
    .period_match(pm0)
  );

  ocp_timebase #(
    .CW(CW)
  ) u_tb1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(run_reg[`OCP_TRUN_RUN1_BIT]),
    .period(per1_reg),
    .cnt_wr(acc_wr && (paddr == `OCP_ADDR_CNT1)),
    .cnt_wdata(merge16(cnt1, pwdata, pstrb)),
    .count(cnt1),
    .period_match(pm1)
  );

  // Timer selection
  assign sel_cnt = tsel_reg ? cnt1 : cnt0; // RULE9 RULE20
  assign sel_per = tsel_reg ? per1_reg : per0_reg; // RULE20
  assign sel_run = tsel_reg ? run_reg[`OCP_TRUN_RUN1_BIT] : run_reg[`OCP_TRUN_RUN0_BIT];
  assign sel_pm = tsel_reg ? pm1 : pm0; // RULE13

  // A stopped timer holds its count; matching only while running avoids repeats
  assign match_p = sel_run && (sel_cnt == pri_reg);
  assign match_s = sel_run && (sel_cnt == sec_reg);

  assign pwm_mode = (mode_reg == `OCP_MODE_PWM) || (mode_reg == `OCP_MODE_PWM_FLT); // RULE21
  // Duty above period keeps the pin high, zero keeps it low
  assign pwm_level = (sel_cnt < pri_reg); // RULE24

  // ----------------------------------------
  // Fault input
  // ----------------------------------------
  ocp_sync #(
    .W(2),
    .RST_LEVEL(1'b1)
  ) u_fault_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({fault_input_b_n, fault_input_a_n}),
    .sync_out(fault_sync_n)
  );

  assign fault_active = (CHANNEL_NUM <= `OCP_LAST_FAULT_A_CHANNEL) ?
    !fault_sync_n[0] : !fault_sync_n[1]; // RULE14

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mode_reg <= `OCP_RST_MODE;
      tsel_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      mode_reg <= new_mode;
      tsel_reg <= pwdata[`OCP_CTRL_TSEL_BIT];
    end
  end

  // ----------------------------------------
  // Compare and period registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pri_reg <= CW'(`OCP_RST_WORD);
    else if (pwm_mode && sel_pm)
      pri_reg <= sec_reg; // RULE11 RULE12
    else if (acc_wr && (paddr == `OCP_ADDR_PRI) && !pwm_mode)
      pri_reg <= merge16(pri_reg, pwdata, pstrb); // RULE10
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sec_reg <= CW'(`OCP_RST_WORD);
    else if (acc_wr && (paddr == `OCP_ADDR_SEC))
      sec_reg <= merge16(sec_reg, pwdata, pstrb);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      per0_reg <= CW'(`OCP_RST_WORD);
      per1_reg <= CW'(`OCP_RST_WORD);
    end
    else if (acc_wr && (paddr == `OCP_ADDR_PER0))
      per0_reg <= merge16(per0_reg, pwdata, pstrb);
    else if (acc_wr && (paddr == `OCP_ADDR_PER1))
      per1_reg <= merge16(per1_reg, pwdata, pstrb);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      run_reg <= 2'h0;
    else if (acc_wr && (paddr == `OCP_ADDR_TRUN) && pstrb[`OCP_STRB_LO])
      run_reg <= pwdata[`OCP_TRUN_RUN1_BIT:`OCP_TRUN_RUN0_BIT];
  end

  // ----------------------------------------
  // Single pulse sequencing
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      sp_state_reg <= SP_DONE;
    else if (ctrl_wr && (new_mode == `OCP_MODE_SINGLE))
      sp_state_reg <= SP_ARMED; // RULE5
    else if (mode_reg == `OCP_MODE_SINGLE)
    begin
      unique case (sp_state_reg)
        SP_ARMED:
          if (match_p)
            sp_state_reg <= SP_HIGH; // RULE2
        SP_HIGH:
          if (match_s)
            sp_state_reg <= SP_DONE; // RULE3
        SP_DONE:
          sp_state_reg <= SP_DONE;
        default:
          sp_state_reg <= SP_DONE;
      endcase
    end
  end

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pin_reg <= 1'b0;
    else if (ctrl_wr)
      pin_reg <= (new_mode == `OCP_MODE_SET_LO); // RULE1 RULE6 RULE22
    else
    begin
      unique case (mode_reg)
        `OCP_MODE_OFF:
          pin_reg <= 1'b0; // RULE22
        `OCP_MODE_SET_HI:
          if (match_p)
            pin_reg <= 1'b1; // RULE22
        `OCP_MODE_SET_LO:
          if (match_p)
            pin_reg <= 1'b0; // RULE22
        `OCP_MODE_TOGGLE:
          if (match_p)
            pin_reg <= !pin_reg; // RULE22
        `OCP_MODE_SINGLE:
          if ((sp_state_reg == SP_ARMED) && match_p)
            pin_reg <= 1'b1; // RULE2
          else if ((sp_state_reg == SP_HIGH) && match_s)
            pin_reg <= 1'b0; // RULE3
        `OCP_MODE_CONT:
          if (match_s)
            pin_reg <= 1'b0; // RULE6
          else if (match_p)
            pin_reg <= 1'b1; // RULE2 RULE6
        `OCP_MODE_PWM:
          pin_reg <= pwm_level; // RULE24
        `OCP_MODE_PWM_FLT:
          pin_reg <= pwm_level && !fault_active && !flt_status_reg; // RULE25
      endcase
    end
  end

  assign compare_output_pin = pin_reg;

  // ----------------------------------------
  // Fault status
  // ----------------------------------------
  // Held until the fault has gone and either a period ends, so the pin restarts cleanly, or a mode other than 111 is written
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      flt_status_reg <= 1'b0;
    else if ((mode_reg == `OCP_MODE_PWM_FLT) && fault_active)
      flt_status_reg <= 1'b1; // RULE25 RULE23
    else if (!fault_active && sel_pm)
      flt_status_reg <= 1'b0; // RULE23
    else if (ctrl_wr && (new_mode != `OCP_MODE_PWM_FLT))
      flt_status_reg <= 1'b0; // RULE23
  end

  // ----------------------------------------
  // Interrupt flag
  // ----------------------------------------
  assign flag_set = ((mode_reg == `OCP_MODE_SINGLE) && (sp_state_reg == SP_HIGH) &&
                     match_s && !ctrl_wr) || // RULE4
                    ((mode_reg == `OCP_MODE_CONT) && match_s) || // RULE8
                    ((mode_reg == `OCP_MODE_PWM_FLT) && fault_active &&
                     !flt_status_reg); // RULE25
  assign flag_clr = acc_wr && (paddr == `OCP_ADDR_IRQ) && pstrb[`OCP_STRB_LO] &&
                    pwdata[`OCP_IRQ_FLAG_BIT];

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_flag_reg <= 1'b0;
    else if (flag_set)
      irq_flag_reg <= 1'b1; // RULE4 RULE8
    else if (flag_clr)
      irq_flag_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_en_reg <= 1'b0;
    else if (acc_wr && (paddr == `OCP_ADDR_IRQ) && pstrb[`OCP_STRB_LO])
      irq_en_reg <= pwdata[`OCP_IRQ_EN_BIT];
  end

  assign compare_irq = irq_flag_reg && irq_en_reg; // RULE4

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    rdata_next = 32'h00000000;
    unique case (paddr)
      `OCP_ADDR_CTRL: rdata_next = 32'({flt_status_reg, tsel_reg, mode_reg});
      `OCP_ADDR_PRI: rdata_next = 32'(pri_reg);
      `OCP_ADDR_SEC: rdata_next = 32'(sec_reg);
      `OCP_ADDR_PER0: rdata_next = 32'(per0_reg);
      `OCP_ADDR_PER1: rdata_next = 32'(per1_reg);
      `OCP_ADDR_TRUN: rdata_next = 32'(run_reg);
      `OCP_ADDR_CNT0: rdata_next = 32'(cnt0);
      `OCP_ADDR_CNT1: rdata_next = 32'(cnt1);
      `OCP_ADDR_IRQ: rdata_next = 32'({irq_en_reg, irq_flag_reg});
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Captured in the setup cycle so the access phase needs no wait states
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rdata_reg <= 32'h00000000;
    else if (setup_phase && !pwrite)
      rdata_reg <= rdata_next;
  end
endmodule

//--- ocp_top_asserts.sv
`timescale 1ns/1ns
module ocp_top_chk #(
  parameter int CHANNEL_NUM = 1
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ocp_pkg::ocp_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire ocp_pkg::ocp_data_t pwdata,
  input wire logic [3:0] pstrb,
  input wire ocp_pkg::ocp_data_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fault_input_a_n,
  input wire logic fault_input_b_n,
  input wire logic compare_output_pin,
  input wire logic compare_irq
);
  import ocp_pkg::*;
  logic wr_acc;
  logic ctrl_wr;
  logic irq_wr;
  logic flt_n;
  logic irq_en_h;
  logic sp_done_h;
  ocp_mode_t mode_h;
  assign wr_acc = psel && penable && pwrite && pready && pstrb[0];
  assign ctrl_wr = wr_acc && paddr == 8'h00;
  assign irq_wr = wr_acc && paddr == 8'h20;
  assign flt_n = (CHANNEL_NUM <= 4) ? fault_input_a_n : fault_input_b_n;
  // ------
  // Shadow state
  // ------
  always_ff @(posedge clk_sys)
    if (!rst_n)
      mode_h <= 3'h0;
    else if (ctrl_wr)
      mode_h <= pwdata[2:0];
  always_ff @(posedge clk_sys)
    if (!rst_n)
      irq_en_h <= 1'b0;
    else if (irq_wr)
      irq_en_h <= pwdata[1];
  // Set one cycle late, so the fall itself is never judged
  always_ff @(posedge clk_sys)
    if (!rst_n || ctrl_wr)
      sp_done_h <= 1'b0;
    // A fall forced by the arming write itself is not the end of a pulse
    else if (mode_h == 3'h4 && !$past(ctrl_wr) && $fell(compare_output_pin))
      sp_done_h <= 1'b1;
  // ------
  // Properties
  // ------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_PREADY: assert property (pready) else $error("pready low");
  AST_ERR_ACC: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  AST_SP_LOW: assert property (
    ctrl_wr && pwdata[2:0] == 3'h4 |=> !compare_output_pin) else $error("single not low");
  AST_CONT_LOW: assert property (
    ctrl_wr && pwdata[2:0] == 3'h5 |=> !compare_output_pin) else $error("cont not low");
  AST_SETLO_INIT: assert property (
    ctrl_wr && pwdata[2:0] == 3'h2 |=> compare_output_pin) else $error("init not high");
  AST_OFF_LOW: assert property (
    mode_h == 3'h0 && !ctrl_wr |=> !compare_output_pin) else $error("off pin high");
  AST_SP_HOLD: assert property (
    sp_done_h && !ctrl_wr |=> !compare_output_pin) else $error("second pulse");
  AST_IRQ_EN: assert property (
    compare_irq |-> irq_en_h) else $error("irq while disabled");
  AST_IRQ_SRC: assert property (
    $rose(compare_irq) && !$past(irq_wr) |-> $past(mode_h) inside {3'h4, 3'h5, 3'h7})
    else $error("irq from wrong mode");
  AST_FAULT: assert property (
    (mode_h == 3'h7 && !flt_n && !ctrl_wr)[*3] |=> !compare_output_pin)
    else $error("fault pin high");
  cover property (sp_done_h);
  cover property (mode_h == 3'h7 && !flt_n);
  cover property ($rose(compare_irq));
endmodule

bind ocp_top ocp_top_chk #(.CHANNEL_NUM(CHANNEL_NUM)) i_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .fault_input_a_n(fault_input_a_n),
  .fault_input_b_n(fault_input_b_n),
  .compare_output_pin(compare_output_pin),
  .compare_irq(compare_irq)
);
